/* File: hdl/rcso_map.svh */
`ifndef RCSO_MAP_SVH
`define RCSO_MAP_SVH

// Stream widths
`define RCSO_DATA_W 512
`define RCSO_SB_W 161
`define RCSO_KEEP_W 16
`define RCSO_CNT_W 5

// Packet start flags inside the sideband bus
`define RCSO_SOP_LSB 64
`define RCSO_SOP_MSB 67
`define RCSO_SOP_W 4

// Reset value of the keep mask, and start flag values
`define RCSO_KEEP_RST 16'h0000
`define RCSO_SOP_NONE 4'h0
`define RCSO_SOP_ONE 4'h1

`endif

/* File: hdl/rcso_pkg.sv */
package rcso_pkg;

  // Framing state of the non-straddled stream
  typedef enum logic [0:0] {
    RCSO_BETWEEN,
    RCSO_INSIDE
  } rcso_frame_t;

endpackage

/* File: hdl/rcso_keep_gen.sv */
`timescale 1ns/10ps
`include "rcso_map.svh"

module rcso_keep_gen
(
  // Beat description
  input wire logic i_straddle_en,
  input wire logic i_last,
  input wire logic [`RCSO_CNT_W-1:0] i_last_dwords,
  // Dword keep result
  output logic [`RCSO_KEEP_W-1:0] o_keep
);

  // One keep bit per dword: full beats and straddle mode keep all, a final beat keeps a prefix
  genvar g;
  generate
    for (g = 0; g < `RCSO_KEEP_W; g = g + 1)
    begin : g_dw
      assign o_keep[g] = i_straddle_en | ~i_last |
                         (i_last_dwords > `RCSO_CNT_W'(g));
    end
  endgenerate

endmodule

/* File: hdl/rcso_stream_out.sv */
`timescale 1ns/10ps
`include "rcso_map.svh"

module rcso_stream_out
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Configuration
  input wire logic i_straddle_en,
  // Internal completion source
  input wire logic i_src_valid,
  input wire logic [`RCSO_DATA_W-1:0] i_src_data,
  input wire logic [`RCSO_SB_W-1:0] i_src_sideband,
  input wire logic i_src_last,
  input wire logic [`RCSO_CNT_W-1:0] i_src_last_dwords,
  output logic o_src_ready,
  // Completion stream to user logic
  output logic [`RCSO_DATA_W-1:0] o_completion_data_out,
  output logic [`RCSO_SB_W-1:0] o_completion_sideband,
  output logic o_completion_last,
  output logic [`RCSO_KEEP_W-1:0] o_completion_dword_keep,
  output logic o_completion_valid,
  input wire logic i_completion_ready,
  // Framing fault from the source
  output logic o_frame_error
);

  rcso_pkg::rcso_frame_t frame_r;
  rcso_pkg::rcso_frame_t frame_nxt;
  logic load;
  logic out_free;
  logic skid_valid_r;
  logic skid_valid_nxt;
  logic [`RCSO_DATA_W-1:0] skid_data_r;
  logic [`RCSO_SB_W-1:0] skid_sideband_r;
  logic skid_last_r;
  logic [`RCSO_KEEP_W-1:0] skid_keep_r;
  logic [`RCSO_SB_W-1:0] beat_sideband;
  logic [`RCSO_SOP_W-1:0] beat_starts;
  logic [`RCSO_KEEP_W-1:0] beat_keep;
  logic beat_last;
  logic frame_error_nxt;
  logic skid_load;

  // Handshake terms for the source and the output stage
  assign load = i_src_valid & o_src_ready;
  assign out_free = ~o_completion_valid | i_completion_ready;
  assign skid_load = load & (skid_valid_r | ~out_free); // Beat cannot reach the output yet

  // Keep mask of the incoming beat
  rcso_keep_gen u_keep
  (
    .i_straddle_en(i_straddle_en),
    .i_last(i_src_last),
    .i_last_dwords(i_src_last_dwords),
    .o_keep(beat_keep)
  );

  // Last flag and start flags of the incoming beat
  always_comb
  begin
    beat_last = i_src_last & ~i_straddle_en;
    if (i_straddle_en)
    begin
      beat_starts = i_src_sideband[`RCSO_SOP_MSB:`RCSO_SOP_LSB];
    end
    else if (frame_r == rcso_pkg::RCSO_BETWEEN)
    begin
      beat_starts = `RCSO_SOP_ONE;
    end
    else
    begin
      beat_starts = `RCSO_SOP_NONE;
    end
    beat_sideband = i_src_sideband;
    beat_sideband[`RCSO_SOP_MSB:`RCSO_SOP_LSB] = beat_starts;
  end

  // Packet framing follows each accepted source beat while straddle is off
  always_comb
  begin
    frame_nxt = frame_r;
    frame_error_nxt = 1'b0;
    if (load && !i_straddle_en)
    begin
      if (i_src_last)
      begin
        frame_nxt = rcso_pkg::RCSO_BETWEEN;
        frame_error_nxt = (i_src_last_dwords == `RCSO_CNT_W'(0)) ||
                          (i_src_last_dwords > `RCSO_CNT_W'(`RCSO_KEEP_W));
      end
      else
      begin
        frame_nxt = rcso_pkg::RCSO_INSIDE;
      end
    end
  end

  // Framing state register
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      frame_r <= rcso_pkg::RCSO_BETWEEN;
    end
    else
    begin
      frame_r <= frame_nxt;
    end
  end

  // Framing fault pulse
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_frame_error <= 1'b0;
    end
    else
    begin
      o_frame_error <= frame_error_nxt;
    end
  end

  // Skid slot fills when the output stage stalls, drains when it frees
  always_comb
  begin
    if (out_free)
    begin
      skid_valid_nxt = skid_valid_r & load;
    end
    else
    begin
      skid_valid_nxt = skid_valid_r | load;
    end
  end

  // Skid occupancy and source ready, both registered
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      skid_valid_r <= 1'b0;
      o_src_ready <= 1'b0;
    end
    else
    begin
      skid_valid_r <= skid_valid_nxt;
      o_src_ready <= ~skid_valid_nxt; // Source may send only while the skid slot is free
    end
  end

  // Skid data captures a beat that cannot reach the output
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      skid_data_r <= '0;
    end
    else if (skid_load)
    begin
      skid_data_r <= i_src_data;
    end
  end

  // Skid sideband, start flags already resolved
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      skid_sideband_r <= '0;
    end
    else if (skid_load)
    begin
      skid_sideband_r <= beat_sideband;
    end
  end

  // Skid last flag
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      skid_last_r <= 1'b0;
    end
    else if (skid_load)
    begin
      skid_last_r <= beat_last;
    end
  end

  // Skid keep mask
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      skid_keep_r <= `RCSO_KEEP_RST;
    end
    else if (skid_load)
    begin
      skid_keep_r <= beat_keep;
    end
  end

  // Output valid: low in reset, held while stalled
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_completion_valid <= 1'b0;
    end
    else if (out_free)
    begin
      o_completion_valid <= skid_valid_r | load;
    end
  end

  // Output data, from the skid slot first to keep order
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_completion_data_out <= '0;
    end
    else if (out_free && skid_valid_r)
    begin
      o_completion_data_out <= skid_data_r;
    end
    else if (out_free && load)
    begin
      o_completion_data_out <= i_src_data;
    end
  end

  // Output sideband, from the skid slot first to keep order
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_completion_sideband <= '0;
    end
    else if (out_free && skid_valid_r)
    begin
      o_completion_sideband <= skid_sideband_r;
    end
    else if (out_free && load)
    begin
      o_completion_sideband <= beat_sideband;
    end
  end

  // Output last flag; a stale flag is cleared once straddle is on
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_completion_last <= 1'b0;
    end
    else if (out_free && skid_valid_r)
    begin
      o_completion_last <= skid_last_r & ~i_straddle_en;
    end
    else if (out_free && load)
    begin
      o_completion_last <= beat_last;
    end
    else if (i_straddle_en)
    begin
      o_completion_last <= 1'b0;
    end
  end

  // Output keep mask; forced full once straddle is on
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_completion_dword_keep <= `RCSO_KEEP_RST;
    end
    else if (out_free && skid_valid_r)
    begin
      o_completion_dword_keep <= skid_keep_r | {`RCSO_KEEP_W{i_straddle_en}};
    end
    else if (out_free && load)
    begin
      o_completion_dword_keep <= beat_keep;
    end
    else if (i_straddle_en)
    begin
      o_completion_dword_keep <= {`RCSO_KEEP_W{1'b1}};
    end
  end

endmodule

/* File: verification/rcso_props.sv */
`timescale 1ns/10ps
`include "rcso_map.svh"
module rcso_props
(
  // Watched ports
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_straddle_en,
  input wire logic [`RCSO_DATA_W-1:0] o_completion_data_out,
  input wire logic [`RCSO_SB_W-1:0] o_completion_sideband,
  input wire logic o_completion_last,
  input wire logic [`RCSO_KEEP_W-1:0] o_completion_dword_keep,
  input wire logic o_completion_valid,
  input wire logic i_completion_ready
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic first_r;
  wire v = o_completion_valid;
  wire [15:0] k = o_completion_dword_keep;
  // Next accepted beat opens a packet
  always_ff @(posedge i_core_clk)
    if (!i_rstn || i_straddle_en) first_r <= 1'b1;
    else if (v && i_completion_ready) first_r <= o_completion_last;
  sequence s_stall; v && !i_completion_ready; endsequence
  property p_hold; s_stall |=> v && $stable(o_completion_data_out); endproperty
  property p_sbh; s_stall |=> $stable(o_completion_sideband); endproperty
  property p_lkh; s_stall |=> $stable(o_completion_last) && $stable(k); endproperty
  property p_rst; $rose(i_rstn) |-> !v; endproperty
  property p_nol; i_straddle_en |-> !o_completion_last; endproperty
  property p_full; v && !o_completion_last |-> k == 16'hffff; endproperty
  property p_cont; v |-> k[0] && ((k + 16'h1) & k) == 16'h0; endproperty
  property p_sop;
    !i_straddle_en && v |-> o_completion_sideband[67:64] == {3'h0, first_r};
  endproperty
  a_hold: assert property (p_hold) else $error("stall lost data");
  a_sbh: assert property (p_sbh) else $error("stall lost sideband");
  a_lkh: assert property (p_lkh) else $error("stall lost last");
  a_rst: assert property (p_rst) else $error("valid after reset");
  a_nol: assert property (p_nol) else $error("last in straddle");
  a_full: assert property (p_full) else $error("keep not full");
  a_cont: assert property (p_cont) else $error("keep gap");
  a_sop: assert property (p_sop) else $error("start flag wrong");
endmodule
bind rcso_stream_out rcso_props i_props (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_straddle_en(i_straddle_en), .o_completion_data_out(o_completion_data_out),
  .o_completion_sideband(o_completion_sideband), .o_completion_last(o_completion_last),
  .o_completion_dword_keep(o_completion_dword_keep),
  .o_completion_valid(o_completion_valid), .i_completion_ready(i_completion_ready));

/* File: verification/rcso_sink.sv */
`timescale 1ns/10ps
module rcso_sink
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Pace
  input wire logic i_slow,
  output logic o_ready
);
  // Ready every cycle, or every other when slow
  always_ff @(posedge i_core_clk)
    if (!i_rstn) o_ready <= 1'b0;
    else o_ready <= !i_slow || !o_ready;
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`include "rcso_map.svh"
module testbench;
  logic clk = 1'b0, rstn = 1'b0, strad = 1'b0, sv = 1'b0, sl = 1'b0, slow = 1'b0;
  logic rdy, srdy, ol, ov, fe;
  logic [511:0] sd = '0, od;
  logic [160:0] ssb = '0, osb;
  logic [4:0] dw = 5'h0;
  logic [15:0] ok;
  logic [52:0] q[$];
  int failures = 0, comparisons = 0;
  rcso_stream_out i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_straddle_en(strad),
    .i_src_valid(sv), .i_src_data(sd), .i_src_sideband(ssb), .i_src_last(sl),
    .i_src_last_dwords(dw), .o_src_ready(srdy), .o_completion_data_out(od),
    .o_completion_sideband(osb), .o_completion_last(ol), .o_completion_dword_keep(ok),
    .o_completion_valid(ov), .i_completion_ready(rdy), .o_frame_error(fe));
  rcso_sink i_sink (.i_core_clk(clk), .i_rstn(rstn), .i_slow(slow), .o_ready(rdy));
  // Clock
  initial forever #5 clk = ~clk;
  // Record accepted beats
  always @(posedge clk)
    if (ov === 1'b1 && rdy === 1'b1) q.push_back({ol, ok, osb[67:64], od[31:0]});
  task automatic chk(input logic [52:0] e);
    logic [52:0] g;
    g = 'x;
    if (q.size() > 0) g = q.pop_front();
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Hold one source beat until taken
  task automatic beat(input logic [31:0] d, input logic l, input logic [4:0] n, input logic [3:0] f);
    sd <= {480'h0, d};
    ssb <= {93'h0, f, 64'h0};
    sl <= l;
    dw <= n;
    sv <= 1'b1;
    @(negedge clk);
    while (srdy !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic drain(input int n);
    sv <= 1'b0;
    for (int i = 0; i < 40 && q.size() < n; i++) @(negedge clk);
    @(posedge clk);
  endtask
  task t_single;
    beat(32'h11, 1'b1, 5'h3, 4'h0);
    drain(1);
    chk({1'b1, 16'h0007, 4'h1, 32'h11});
    $display("single done");
  endtask
  task t_multi;
    slow <= 1'b1;
    beat(32'h21, 1'b0, 5'h0, 4'h0);
    beat(32'h22, 1'b0, 5'h0, 4'h0);
    beat(32'h23, 1'b1, 5'h10, 4'h0);
    beat(32'h24, 1'b1, 5'h1, 4'h0);
    drain(4);
    chk({1'b0, 16'hffff, 4'h1, 32'h21});
    chk({1'b0, 16'hffff, 4'h0, 32'h22});
    chk({1'b1, 16'hffff, 4'h0, 32'h23});
    chk({1'b1, 16'h0001, 4'h1, 32'h24});
    slow <= 1'b0;
    $display("multi done");
  endtask
  // Straddle is entered under reset, as the option is static, and left at the end without reset
  task t_strad;
    rstn <= 1'b0;
    strad <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    comparisons++;
    if (ov !== 1'b0)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, ov, 1'b0);
    end
    beat(32'h31, 1'b1, 5'h2, 4'h3);
    beat(32'h32, 1'b0, 5'h0, 4'h0);
    drain(2);
    chk({1'b0, 16'hffff, 4'h3, 32'h31});
    chk({1'b0, 16'hffff, 4'h0, 32'h32});
    strad <= 1'b0;
    $display("straddle done");
  endtask
  // Final beat with too many dwords raises a one-cycle fault pulse
  task t_ferr;
    beat(32'h41, 1'b1, 5'h11, 4'h0);
    sv <= 1'b0;
    for (int i = 1; i >= 0; i--)
    begin
      @(negedge clk);
      comparisons++;
      if (fe !== i[0])
      begin
        failures++;
        $display("[ERR] %0t got %h exp %h", $time, fe, i[0]);
      end
    end
    drain(1);
    chk({1'b1, 16'hffff, 4'h1, 32'h41});
    $display("frame error done");
  endtask
  task end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_single;
    t_multi;
    t_strad;
    t_ferr;
    end_sim;
  end
  // Watchdog
  initial
  begin
    #20000;
    failures++;
    end_sim;
  end
endmodule
